/* File: core/qdsl_pkg.sv */
// shared constants for the quad converter serial load link
package qdsl_pkg;
    // word layout, first bit shifted in sits at the top
    localparam int WORD_W   = 16;
    localparam int CODE_W   = 12;
    localparam int ADDR_W   = 2;
    localparam int CHAN_N   = 4;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 14;
    localparam int CODE_MSB = 11;
    localparam int CODE_LSB = 0;
    localparam logic [ADDR_W-1:0] UNUSED_BITS = 2'h0;

    // reset codes chosen by the level select input
    localparam logic [CODE_W-1:0] RESET_ZERO = 12'h000;
    localparam logic [CODE_W-1:0] RESET_MID  = 12'h800;

    // host command opcodes
    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_LOAD  = 2'h1,
        OP_RESET = 2'h2
    } qdsl_op_t;

    // link timing in ns and the mclk period
    localparam int MCLK_NS = 5;
    localparam int T_CH_NS   = 30;
    localparam int T_CL_NS   = 50;
    localparam int T_CSS_NS  = 55;
    localparam int T_CSH_NS  = 15;
    localparam int T_LD1_NS  = 40;
    localparam int T_LD2_NS  = 15;
    localparam int T_LDDW_NS = 45;
    localparam int T_RSSH_NS = 25;
    localparam int T_RSTW_NS = 70;

    // least time rounded up to whole mclk cycles, at least one
    function automatic int minCycles(input int ns);
        int c;
        c = (ns + MCLK_NS - 1) / MCLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CNT_W    = 5;
    localparam int T_CH_CYC   = minCycles(T_CH_NS);
    localparam int T_CL_CYC   = minCycles(T_CL_NS);
    localparam int T_CSS_CYC  = minCycles(T_CSS_NS);
    localparam int T_CSH_CYC  = minCycles(T_CSH_NS);
    localparam int T_LD1_CYC  = minCycles(T_LD1_NS);
    localparam int T_LD2_CYC  = minCycles(T_LD2_NS);
    localparam int T_LDDW_CYC = minCycles(T_LDDW_NS);
    localparam int T_RSSH_CYC = minCycles(T_RSSH_NS);
    localparam int T_RSTW_CYC = minCycles(T_RSTW_NS);
endpackage

/* File: core/qdsl_link_if.sv */
// link wires between the serial master and the converter load logic
`timescale 1ns/1ps
`default_nettype none
interface qdsl_link_if;
    logic csN;              // chip select, active low
    logic sclk;             // serial clock, made by the host
    logic serialIn;         // serial data
    logic loadStrobeN;      // channel load strobe, active low
    logic resetN;           // asynchronous reset, active low
    logic resetLevelSelect; // reset code: low zero, high mid-scale

    modport host (
        output csN,
        output sclk,
        output serialIn,
        output loadStrobeN,
        output resetN,
        output resetLevelSelect
    );
    modport device (
        input csN,
        input sclk,
        input serialIn,
        input loadStrobeN,
        input resetN,
        input resetLevelSelect
    );
endinterface
`default_nettype wire

/* File: core/qdsl_device.sv */
// converter end: serial shift register, address decode, channel registers
`timescale 1ns/1ps
`default_nettype none
module qdsl_device (
    qdsl_link_if.device                              link,     // serial link, device side
    output var logic [qdsl_pkg::CHAN_N-1:0][qdsl_pkg::CODE_W-1:0] chanCode // channel values
);
    logic                          shiftClk;
    logic [qdsl_pkg::WORD_W-1:0]   shiftQ;
    logic [qdsl_pkg::WORD_W-1:0]   shiftD;
    logic [qdsl_pkg::CODE_W-1:0]   resetCode;

    // chip select and clock merged by one OR gate
    assign shiftClk = link.csN | link.sclk;

    // new bit enters at the bottom, so the first bit ends at the top
    always_comb begin
        shiftD = {shiftQ[qdsl_pkg::WORD_W-2:0], link.serialIn};
    end

    // no reset here: the transfer in progress survives a reset pulse
    always_ff @(posedge shiftClk) begin
        shiftQ <= shiftD;
    end

    assign resetCode = link.resetLevelSelect ? qdsl_pkg::RESET_MID
                                             : qdsl_pkg::RESET_ZERO;

    // channel registers are level-sensitive latches with an async reset to the selected reset code
    always_latch begin
        if (!link.resetN) begin
            for (int i = 0; i < qdsl_pkg::CHAN_N; i++) begin
                chanCode[i] = resetCode;
            end
        end else if (!link.loadStrobeN) begin
            // fields read live from one source: a shift under a low strobe moves the target
            chanCode[shiftQ[qdsl_pkg::ADDR_MSB:qdsl_pkg::ADDR_LSB]] =
                shiftQ[qdsl_pkg::CODE_MSB:qdsl_pkg::CODE_LSB];
        end
        // strobe high: every channel holds, including a fresh reset code
    end
endmodule // qdsl_device
`default_nettype wire

/* File: core/qdsl_host.sv */
// serial master: sends words, pulses load strobe and reset on request
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - word is address, two spare, twelve code
// - address bits first, then two ignored
// - code fills last twelve bits, msb first
// - address 00..11 picks channel A..D
// - strobe low: addressed channel transparent; high holds
// - reset low forces all channels, level chosen
// - latched channels keep reset code after release
// - reset never touches the shift register
// - shift one bit per OR rising edge
// - chip select and clock are interchangeable
// - select rising with clock low shifts extra
// - host raises select only with clock high
// - shifting with strobe low corrupts passed channels
// - host holds select high around strobe, reset
// - code is straight unsigned binary
module qdsl_host (
    input  wire logic                            mclk,      // system clock
    input  wire logic                            nrst,      // sync reset, active low
    input  wire logic                            clkEn,     // freezes state when low
    input  wire logic                            cmdValid,  // command request
    input  wire qdsl_pkg::qdsl_op_t              cmdOp,     // write, load or reset
    input  wire logic [qdsl_pkg::ADDR_W-1:0]     cmdChan,   // channel for write
    input  wire logic [qdsl_pkg::CODE_W-1:0]     cmdCode,   // code for write
    input  wire logic                            cmdLevel,  // reset level for reset
    output logic                                 cmdReady,  // idle, takes a command
    qdsl_link_if.host                            link       // serial link, host side
);
    // one-hot sequencer states
    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_LOW    = 7'h02,
        ST_HIGH   = 7'h04,
        ST_LDWAIT = 7'h08,
        ST_LOAD   = 7'h10,
        ST_RSEL   = 7'h20,
        ST_RST    = 7'h40
    } qdsl_state_t;

    // counts the bits of the word in flight
    localparam int BIT_W = 4;
    localparam logic [BIT_W-1:0] LAST_BIT = 4'(qdsl_pkg::WORD_W - 1);

    qdsl_state_t                  stateQ, stateD;
    logic [qdsl_pkg::CNT_W-1:0]   cntQ, cntD;
    logic [BIT_W-1:0]             bitQ, bitD;
    logic [qdsl_pkg::WORD_W-1:0]  wordQ, wordD;
    logic                         sclkQ, sclkD;
    logic                         csNQ, csND;
    logic                         sdiQ, sdiD;
    logic                         ldNQ, ldND;
    logic                         rstNQ, rstND;
    logic                         selQ, selD;
    logic                         readyQ, readyD;

    // counter load: the state moves on once the count reaches zero
    function automatic logic [qdsl_pkg::CNT_W-1:0] preset(input int cyc);
        return qdsl_pkg::CNT_W'(cyc - 1);
    endfunction

    always_comb begin
        stateD = stateQ;
        cntD   = (cntQ != '0) ? cntQ - 1'b1 : cntQ;
        bitD   = bitQ;
        wordD  = wordQ;
        sclkD  = sclkQ;
        csND   = csNQ;
        sdiD   = sdiQ;
        ldND   = ldNQ;
        rstND  = rstNQ;
        selD   = selQ;
        readyD = readyQ;
        case (stateQ)
            // idle: a command is taken only here, ready is high
            ST_IDLE: begin
                if (cmdValid) begin
                    readyD = 1'b0;
                    case (cmdOp)
                        qdsl_pkg::OP_WRITE: begin
                            wordD  = {cmdChan, qdsl_pkg::UNUSED_BITS, cmdCode};
                            sdiD   = cmdChan[qdsl_pkg::ADDR_W-1];
                            csND   = 1'b0;
                            sclkD  = 1'b0;
                            bitD   = '0;
                            cntD   = preset(qdsl_pkg::T_CSS_CYC);
                            stateD = ST_LOW;
                        end
                        qdsl_pkg::OP_LOAD: begin
                            cntD   = preset(qdsl_pkg::T_LD1_CYC);
                            stateD = ST_LDWAIT;
                        end
                        qdsl_pkg::OP_RESET: begin
                            selD   = cmdLevel;
                            cntD   = preset(qdsl_pkg::T_RSSH_CYC);
                            stateD = ST_RSEL;
                        end
                        default: readyD = 1'b1;
                    endcase
                end
            end
            // low phase: data already set up, wait for the rising edge
            ST_LOW: begin
                if (cntQ == '0) begin
                    sclkD  = 1'b1;
                    cntD   = preset(qdsl_pkg::T_CH_CYC);
                    stateD = ST_HIGH;
                end
            end
            // high phase: the frame ends with the clock still high
            ST_HIGH: begin
                if (cntQ == '0) begin
                    if (bitQ == LAST_BIT) begin
                        csND   = 1'b1; // clock still high here
                        readyD = 1'b1;
                        stateD = ST_IDLE;
                    end else begin
                        wordD  = {wordQ[qdsl_pkg::WORD_W-2:0], 1'b0};
                        sdiD   = wordQ[qdsl_pkg::WORD_W-2]; // msb first
                        bitD   = bitQ + 1'b1;
                        sclkD  = 1'b0;
                        cntD   = preset(qdsl_pkg::T_CL_CYC);
                        stateD = ST_LOW;
                    end
                end
            end
            // gap between the last rising edge and the strobe
            ST_LDWAIT: begin
                if (cntQ == '0) begin
                    ldND   = 1'b0; // select stays high meanwhile
                    cntD   = preset(qdsl_pkg::T_LDDW_CYC);
                    stateD = ST_LOAD;
                end
            end
            // strobe held low for its minimum width
            ST_LOAD: begin
                if (cntQ == '0) begin
                    ldND   = 1'b1;
                    readyD = 1'b1;
                    stateD = ST_IDLE;
                end
            end
            // level select settles before reset falls
            ST_RSEL: begin
                if (cntQ == '0) begin
                    rstND  = 1'b0; // select stays high meanwhile
                    cntD   = preset(qdsl_pkg::T_RSTW_CYC);
                    stateD = ST_RST;
                end
            end
            // reset held low for its minimum width
            ST_RST: begin
                if (cntQ == '0) begin
                    rstND  = 1'b1;
                    readyD = 1'b1;
                    stateD = ST_IDLE;
                end
            end
            // illegal code: recover to idle
            default: begin
                stateD = ST_IDLE;
                readyD = 1'b1;
            end
        endcase
    end

    // clkEn low freezes every flop, reset still wins
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            stateQ <= ST_IDLE;
            cntQ   <= '0;
            bitQ   <= '0;
            wordQ  <= '0;
            sclkQ  <= 1'b1;
            csNQ   <= 1'b1;
            sdiQ   <= 1'b0;
            ldNQ   <= 1'b1;
            rstNQ  <= 1'b1;
            selQ   <= 1'b0;
            readyQ <= 1'b1;
        end else if (clkEn) begin
            stateQ <= stateD;
            cntQ   <= cntD;
            bitQ   <= bitD;
            wordQ  <= wordD;
            sclkQ  <= sclkD;
            csNQ   <= csND;
            sdiQ   <= sdiD;
            ldNQ   <= ldND;
            rstNQ  <= rstND;
            selQ   <= selD;
            readyQ <= readyD;
        end
    end

    // every output comes straight from a flop
    assign cmdReady              = readyQ;
    assign link.sclk             = sclkQ;
    assign link.csN              = csNQ;
    assign link.serialIn         = sdiQ;
    assign link.loadStrobeN      = ldNQ;
    assign link.resetN           = rstNQ;
    assign link.resetLevelSelect = selQ;
endmodule // qdsl_host
`default_nettype wire

/* File: verification/qdsl_link_asserts.sv */
// concurrent checks on the host-driven link and the converter channels
`timescale 1ns/1ps
`default_nettype none
module qdsl_link_asserts (
    input wire logic mclk, // system clock
    input wire logic nrst, // sync reset
    input wire logic csN, // chip select
    input wire logic sclk, // serial clock
    input wire logic loadStrobeN, // load strobe
    input wire logic resetN, // converter reset
    input wire logic resetLevelSelect, // reset level
    input wire logic [qdsl_pkg::CHAN_N-1:0][qdsl_pkg::CODE_W-1:0] chanCode // channel values
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic orPrev_q, orPrev_d, csPrev_q, csPrev_d;
    logic [4:0] cnt_q, cnt_d;
    // counts shift edges inside one frame
    always_comb begin
        orPrev_d = nrst ? (csN | sclk) : 1'h1;
        csPrev_d = nrst ? csN : 1'h1;
        cnt_d = cnt_q;
        if (!nrst || (csPrev_q && !csN)) cnt_d = 5'h0;
        else if (!orPrev_q && (csN | sclk)) cnt_d = cnt_q + 5'h1;
    end
    always_ff @(posedge mclk) begin
        orPrev_q <= orPrev_d;
        csPrev_q <= csPrev_d;
        cnt_q <= cnt_d;
    end
    sequence sClkHigh; sclk [*6]; endsequence
    sequence sClkLow; !sclk [*8]; endsequence
    sequence sStrobeLow; !loadStrobeN [*8]; endsequence
    sequence sResetLow; !resetN [*8]; endsequence
    chk_sclk_high: assert property ($rose(sclk) |-> sClkHigh)
        else $error("sclk high phase too short");
    chk_sclk_low: assert property ($fell(sclk) |-> sClkLow)
        else $error("sclk low phase too short");
    chk_strobe_width: assert property ($fell(loadStrobeN) |-> sStrobeLow)
        else $error("load strobe pulse too short");
    chk_reset_width: assert property ($fell(resetN) |-> sResetLow)
        else $error("reset pulse too short");
    chk_strobe_quiet: assert property (!loadStrobeN |-> csN && resetN)
        else $error("strobe low outside quiet link");
    chk_reset_quiet: assert property (!resetN |-> csN && loadStrobeN)
        else $error("reset low with select active");
    chk_cs_rise: assert property ($rose(csN) |-> sclk)
        else $error("select rose with sclk low");
    chk_word_len: assert property ($rose(csN) |-> cnt_q == 5'h10)
        else $error("frame did not hold sixteen shifts");
    chk_level_hold: assert property (!resetN |-> $stable(resetLevelSelect))
        else $error("level select moved during reset");
    chk_reset_code: assert property (!resetN |-> chanCode == {4{resetLevelSelect ?
        qdsl_pkg::RESET_MID : qdsl_pkg::RESET_ZERO}})
        else $error("channels not at reset code");
endmodule // qdsl_link_asserts
`default_nettype wire

/* File: verification/quad_dac_serial_load_logic_bench.sv */
// bench: host drives one converter; a second converter is driven by hand
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_load_logic_bench;
    typedef logic [qdsl_pkg::CHAN_N-1:0][qdsl_pkg::CODE_W-1:0] qdsl_chan_t;
    logic mclk, nrst, clkEn, cmdValid, cmdLevel, cmdReady;
    qdsl_pkg::qdsl_op_t cmdOp;
    logic [1:0] cmdChan, lastChan;
    logic [11:0] cmdCode, lastCode;
    qdsl_chan_t chanCode, chanCode2, model, m2;
    qdsl_chan_t expQ[$];
    int nFail, samplesChecked;
    logic [31:0] lfsr, enLfsr;
    qdsl_link_if link ();
    qdsl_link_if link2 ();
    qdsl_host u_qdsl_host (.mclk(mclk), .nrst(nrst), .clkEn(clkEn), .cmdValid(cmdValid),
        .cmdOp(cmdOp), .cmdChan(cmdChan), .cmdCode(cmdCode), .cmdLevel(cmdLevel),
        .cmdReady(cmdReady), .link(link));
    qdsl_device u_qdsl_device (.link(link), .chanCode(chanCode));
    qdsl_device u_qdsl_device_b (.link(link2), .chanCode(chanCode2));
    qdsl_link_asserts u_qdsl_link_asserts (.mclk(mclk), .nrst(nrst), .csN(link.csN),
        .sclk(link.sclk), .loadStrobeN(link.loadStrobeN), .resetN(link.resetN),
        .resetLevelSelect(link.resetLevelSelect), .chanCode(chanCode));
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // random clock enable, high three times in four, changed at the falling edge
    initial begin
        enLfsr = 32'h0000_3c5c;
        clkEn = 1'h1;
        forever begin
            @(negedge mclk);
            enLfsr = nextRand(enLfsr);
            clkEn = (enLfsr[1:0] != 2'h0);
        end
    end
    task automatic checkChan(input qdsl_chan_t got, input qdsl_chan_t exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            nFail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // notes the expected channels, then runs one host command to completion
    task automatic issue(input qdsl_pkg::qdsl_op_t op, input logic [1:0] ch,
                         input logic [11:0] code, input logic lvl);
        int k;
        if (op == qdsl_pkg::OP_WRITE) begin
            lastChan = ch;
            lastCode = code;
        end
        if (op == qdsl_pkg::OP_LOAD) model[lastChan] = lastCode;
        if (op == qdsl_pkg::OP_RESET) model = {4{lvl ? qdsl_pkg::RESET_MID : qdsl_pkg::RESET_ZERO}};
        expQ.push_back(model);
        cmdOp = op;
        cmdChan = ch;
        cmdCode = code;
        cmdLevel = lvl;
        cmdValid = 1'h1;
        @(negedge mclk);
        k = 1;
        // hold the request until ready has dropped, i.e. it was taken
        while (cmdReady === 1'h1 && k < 1000) begin
            @(negedge mclk);
            k++;
        end
        cmdValid = 1'h0;
        while (cmdReady !== 1'h1 && k < 1000) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 1000) begin
            nFail++;
            $display("CHECK FAILED at %0t: command timed out", $time);
        end
    endtask
    // pulses the chosen clock line low then high once per bit
    task automatic shift2(input logic [15:0] w, input logic useCs);
        for (int i = 15; i >= 0; i--) begin
            if (useCs) link2.csN = 1'h0;
            else link2.sclk = 1'h0;
            link2.serialIn = w[i];
            #6;
            if (useCs) link2.csN = 1'h1;
            else link2.sclk = 1'h1;
            #6;
        end
        link2.serialIn = ~w[0];
    endtask
    task automatic load2();
        link2.loadStrobeN = 1'h0;
        #60;
        link2.loadStrobeN = 1'h1;
        #12;
    endtask
    initial begin
        logic rdyPrev;
        rdyPrev = 1'h1;
        forever begin
            @(posedge mclk);
            #1;
            if (cmdReady === 1'h1 && rdyPrev === 1'h0 && expQ.size() > 0)
                checkChan(chanCode, expQ.pop_front(), "channels");
            rdyPrev = cmdReady;
        end
    end
    initial begin
        #100000;
        nFail++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        logic [15:0] r;
        {cmdValid, cmdLevel, cmdChan, cmdCode, nrst, nFail, samplesChecked} = '0;
        cmdOp = qdsl_pkg::OP_WRITE;
        lfsr = 32'h0000_3c5c;
        {link2.csN, link2.sclk, link2.serialIn, link2.loadStrobeN} = 4'h d;
        {link2.resetN, link2.resetLevelSelect} = 2'h1;
        repeat (8) @(negedge mclk);
        nrst = 1'h1;
        for (int i = 1; i >= 0; i--) issue(qdsl_pkg::OP_RESET, 2'h0, 12'h000, i[0]);
        for (int i = 0; i < 8; i++) begin
            lfsr = nextRand(lfsr);
            issue(qdsl_pkg::OP_WRITE, i[1:0], (i == 7) ? 12'hfff : lfsr[11:0], 1'h0);
            issue(qdsl_pkg::OP_LOAD, 2'h0, 12'h000, 1'h0);
        end
        issue(qdsl_pkg::OP_WRITE, 2'h2, 12'h5a5, 1'h0);
        issue(qdsl_pkg::OP_RESET, 2'h0, 12'h000, 1'h1);
        issue(qdsl_pkg::OP_LOAD, 2'h0, 12'h000, 1'h0);
        link2.resetN = 1'h1;
        m2 = {4{qdsl_pkg::RESET_MID}};
        checkChan(chanCode2, m2, "reset");
        link2.sclk = 1'h0;
        #12;
        shift2(16'hfc3a, 1'h1);
        m2[3] = 12'hc3a;
        load2();
        checkChan(chanCode2, m2, "select clock");
        link2.sclk = 1'h1;
        #12;
        link2.csN = 1'h0;
        r = 16'h4b5a;
        shift2(r, 1'h0);
        link2.sclk = 1'h0;
        link2.serialIn = 1'h1;
        #12;
        link2.csN = 1'h1;
        #12;
        r = {r[14:0], 1'h1};
        m2[r[15:14]] = r[11:0];
        load2();
        checkChan(chanCode2, m2, "extra shift");
        link2.sclk = 1'h1;
        #12;
        link2.csN = 1'h0;
        link2.loadStrobeN = 1'h0;
        shift2(16'h1e0f, 1'h0);
        for (int i = 15; i >= 0; i--) begin
            r = {r[14:0], i[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'hc}};
            m2[r[15:14]] = r[11:0];
        end
        link2.loadStrobeN = 1'h1;
        link2.csN = 1'h1;
        #12;
        checkChan(chanCode2, m2, "flow through");
        summarize();
    end
endmodule // quad_dac_serial_load_logic_bench
`default_nettype wire
